/* File: rtl/icdt_channel.sv */
// input capture channel with dedicated 16-bit time base and four-entry fifo
// Behaviour
// - free-running counter counts up on selected clock, wraps ffff to 0000
// - each qualifying capture pushes current counter value into fifo unless the fifo is full
// - synchronous mode runs once clock enabled; sync event clears counter
// - trigger mode holds counter until a trigger event arrives
// - selector zero and trigger bit clear is free; nonzero picks sync or trigger
// - selector zero with trigger bit set waits for software to set trigger status
// - cascade: odd holds low half, even high half, odd wrap increments even
// - cascade only when both channels set cascade enable; else 16-bit alone
// - cascaded even channel with trigger bit clear follows odd channel
// - synchronous channel held in reset until its sync source is enabled
// - not-empty flag set while fifo holds data, clears when read empty
// - capture fifo holds four entries
// - read-only overflow flag set by hardware on capture overflow
// - mode field picks off, every edge, falling, rising, every 4th or 16th rising
// - mode 111 is a rising-edge interrupt pin during sleep or idle only
// - rate field interrupts every first to fourth capture
// - every-edge mode ignores the rate field
// - time base select picks system clock or one of five timer ticks
// - stop-in-idle halts the channel during idle, else keeps running
// - trigger status set by hardware or software; clear holds counter at zero
//
// The register addresses and strobed register access were left to the implementer.
`default_nettype none
module icdt_channel #(
    parameter bit IS_ODD = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic capture_input_i,
    input wire logic [4:0] timer_tick_i,
    input wire logic [icdt_pkg::SRC_N-1:0] sync_event_i,
    input wire logic [icdt_pkg::SRC_N-1:0] sync_enabled_i,
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    input wire logic partner_cascade_i,
    input wire logic partner_wrap_i,
    input wire logic partner_run_i,
    input wire logic partner_clear_i,
    output logic cascade_o,
    output logic wrap_o,
    output logic run_o,
    output logic clear_o,
    output logic capture_irq_o
);
    logic [15:0] ctrl1_reg;
    logic [8:0] ctrl2_reg;
    logic [icdt_pkg::CNT_W-1:0] cnt_reg;
    logic [icdt_pkg::CNT_W-1:0] cnt_next;
    logic [icdt_pkg::PTR_W-1:0] wptr_reg;
    logic [icdt_pkg::PTR_W-1:0] rptr_reg;
    logic [icdt_pkg::PTR_W:0] fill_reg;
    logic ovf_reg;
    logic [1:0] irq_cnt_reg;
    logic irq_reg;
    logic rd_fifo_reg;
    logic rd_ctrl_reg;
    logic [15:0] rd_hold_reg;
    logic [icdt_pkg::CNT_W-1:0] fifo_rdata;
    logic [2:0] mode;
    logic [1:0] rate;
    logic [2:0] tsel;
    logic [4:0] sync_sel;
    logic trig_bit;
    logic tstat;
    logic casc_bit;
    logic sidl;
    logic cascaded;
    logic follow_odd;
    logic tick;
    logic sync_evt;
    logic sync_en;
    logic halted;
    logic active;
    logic run;
    logic clear_cnt;
    logic cap_evt;
    logic pin_rise;
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic hw_trig;
    logic wr_c1;
    logic wr_c2;
    logic tick_sel;
    icdt_pkg::icdt_tb_mode_e tb_mode;
    assign mode = ctrl1_reg[icdt_pkg::C1_MODE_LSB +: 3];
    assign rate = ctrl1_reg[icdt_pkg::C1_RATE_LSB +: 2];
    assign tsel = ctrl1_reg[icdt_pkg::C1_TSEL_LSB +: 3];
    assign sidl = ctrl1_reg[icdt_pkg::C1_SIDL];
    assign sync_sel = ctrl2_reg[icdt_pkg::C2_SYNC_LSB +: 5];
    assign tstat = ctrl2_reg[icdt_pkg::C2_TSTAT];
    assign trig_bit = ctrl2_reg[icdt_pkg::C2_TRIG];
    assign casc_bit = ctrl2_reg[icdt_pkg::C2_CASC];
    assign wr_c1 = wr_i & (addr_i == icdt_pkg::ADDR_CTRL1);
    assign wr_c2 = wr_i & (addr_i == icdt_pkg::ADDR_CTRL2);
    assign cascaded = casc_bit & partner_cascade_i;
    assign follow_odd = cascaded & ~IS_ODD & ~trig_bit;
    // clock source selection; reserved codes give no ticks
    always_comb begin
        case (tsel)
            icdt_pkg::TSEL_SYS: tick_sel = 1'b1;
            icdt_pkg::TSEL_T1: tick_sel = timer_tick_i[0];
            icdt_pkg::TSEL_T2: tick_sel = timer_tick_i[1];
            icdt_pkg::TSEL_T3: tick_sel = timer_tick_i[2];
            icdt_pkg::TSEL_T4: tick_sel = timer_tick_i[3];
            icdt_pkg::TSEL_T5: tick_sel = timer_tick_i[4];
            default: tick_sel = 1'b0;
        endcase
    end
    assign tick = follow_odd ? partner_wrap_i : tick_sel;
    assign sync_evt = sync_event_i[sync_sel];
    assign sync_en = sync_enabled_i[sync_sel];
    // time base mode decode
    always_comb begin
        if (sync_sel == icdt_pkg::SYNC_NONE) begin
            tb_mode = trig_bit ? icdt_pkg::ICDT_SWTRIG : icdt_pkg::ICDT_FREE;
        end else begin
            tb_mode = trig_bit ? icdt_pkg::ICDT_TRIG : icdt_pkg::ICDT_SYNC;
        end
    end
    assign halted = sidl & cpu_idle_i;
    assign active = (mode != icdt_pkg::MODE_OFF) & (mode != icdt_pkg::MODE_UNUSED)
                    & (mode != icdt_pkg::MODE_INTPIN) & ~halted;
    assign hw_trig = (tb_mode == icdt_pkg::ICDT_TRIG) & sync_evt & active;
    // running and clearing conditions
    always_comb begin
        run = 1'b0;
        clear_cnt = 1'b0;
        case (tb_mode)
            icdt_pkg::ICDT_FREE: run = active;
            icdt_pkg::ICDT_SYNC: begin
                run = active & sync_en;
                clear_cnt = ~sync_en | sync_evt;
            end
            icdt_pkg::ICDT_TRIG, icdt_pkg::ICDT_SWTRIG: begin
                run = active & tstat;
                clear_cnt = ~tstat;
            end
            default: run = 1'b0;
        endcase
        if (follow_odd) begin
            run = partner_run_i & active;
            clear_cnt = partner_clear_i;
        end
    end
    assign run_o = run;
    assign clear_o = clear_cnt;
    assign cascade_o = casc_bit;
    assign wrap_o = run & tick & (cnt_reg == icdt_pkg::CNT_MAX);
    always_comb begin
        cnt_next = cnt_reg;
        if (clear_cnt) begin
            cnt_next = icdt_pkg::CNT_ZERO;
        end else if (run & tick) begin
            cnt_next = 16'(cnt_reg + 16'h0001);
        end
    end
    icdt_edge_det u_edge (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .capture_input_i(capture_input_i),
        .run_i(active & (run | tb_mode == icdt_pkg::ICDT_SYNC)),
        .capture_mode_sel_i(mode),
        .event_o(cap_evt),
        .rise_o(pin_rise)
    );
    assign full = (fill_reg == 3'(icdt_pkg::FIFO_DEPTH));
    assign empty = (fill_reg == 3'h0);
    assign push = cap_evt & ~full;
    assign pop = rd_i & (addr_i == icdt_pkg::ADDR_FIFO) & ~empty;
    icdt_fifo_mem u_mem (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(push),
        .wr_addr_i(wptr_reg),
        .wr_data_i(cnt_reg),
        .rd_addr_i(rptr_reg),
        .rd_data_o(fifo_rdata)
    );
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl1_reg <= icdt_pkg::C1_RESET;
            ctrl2_reg <= {4'h0, icdt_pkg::SYNC_RESET};
            cnt_reg <= icdt_pkg::CNT_ZERO;
        end else begin
            if (wr_c1) begin
                ctrl1_reg <= wdata_i;
            end
            if (wr_c2 | hw_trig) begin
                ctrl2_reg <= wr_c2 ? wdata_i[8:0] : ctrl2_reg;
                ctrl2_reg[icdt_pkg::C2_TSTAT] <= hw_trig | (wr_c2 & wdata_i[icdt_pkg::C2_TSTAT]);
            end
            cnt_reg <= cnt_next;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fill_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            wptr_reg <= push ? 2'(wptr_reg + 2'h1) : wptr_reg;
            rptr_reg <= pop ? 2'(rptr_reg + 2'h1) : rptr_reg;
            fill_reg <= 3'(fill_reg + {2'h0, push} - {2'h0, pop});
            ovf_reg <= (cap_evt & full) | (ovf_reg & active);
        end
    end
    // interrupt counting: rate ignored in every-edge mode, pin mode in low power
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_cnt_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            if (mode == icdt_pkg::MODE_INTPIN) begin
                irq_reg <= pin_rise & (cpu_sleep_i | cpu_idle_i);
                irq_cnt_reg <= 2'h0;
            end else if (mode == icdt_pkg::MODE_OFF) begin
                irq_cnt_reg <= 2'h0;
            end else if (push & (mode == icdt_pkg::MODE_EDGE)) begin
                irq_reg <= 1'b1;
            end else if (push) begin
                irq_reg <= (irq_cnt_reg == rate);
                irq_cnt_reg <= (irq_cnt_reg == rate) ? 2'h0 : 2'(irq_cnt_reg + 2'h1);
            end
        end
    end
    assign capture_irq_o = irq_reg;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_fifo_reg <= 1'b0;
            rd_ctrl_reg <= 1'b0;
            rd_hold_reg <= 16'h0000;
        end else begin
            rd_fifo_reg <= rd_i & (addr_i == icdt_pkg::ADDR_FIFO);
            rd_ctrl_reg <= rd_i & (addr_i != icdt_pkg::ADDR_FIFO);
            case (addr_i)
                icdt_pkg::ADDR_CTRL1: begin
                    rd_hold_reg <= {2'h0, ctrl1_reg[13:10], 3'h0, ctrl1_reg[6:5], ovf_reg, ~empty, ctrl1_reg[2:0]};
                end
                icdt_pkg::ADDR_CTRL2: rd_hold_reg <= {7'h00, ctrl2_reg[8:6], 1'b0, ctrl2_reg[4:0]};
                icdt_pkg::ADDR_COUNT: rd_hold_reg <= cnt_reg;
                default: rd_hold_reg <= 16'h0000;
            endcase
        end
    end
    assign rdata_o = rd_fifo_reg ? fifo_rdata : (rd_ctrl_reg ? rd_hold_reg : 16'h0000);
    a_fifo_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fill_reg <= 3'(icdt_pkg::FIFO_DEPTH)) else $error("fifo fill above depth");
    a_push_grows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        push && !pop |=> fill_reg == $past(fill_reg) + 3'h1) else $error("push lost");
    a_wrap_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wrap_o && !clear_cnt |=> cnt_reg == icdt_pkg::CNT_ZERO) else $error("no wrap to zero");
    a_hold_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tb_mode == icdt_pkg::ICDT_TRIG && !tstat && !follow_odd |=> cnt_reg == icdt_pkg::CNT_ZERO)
        else $error("counter runs untriggered");
    a_sync_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        tb_mode == icdt_pkg::ICDT_SYNC && sync_evt && !follow_odd |=> cnt_reg == icdt_pkg::CNT_ZERO)
        else $error("sync did not clear");
    a_ovf_full: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cap_evt && full |=> ovf_reg) else $error("overflow not flagged");
    a_trig_sets: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_trig |=> ctrl2_reg[icdt_pkg::C2_TSTAT]) else $error("trigger status not set");
    a_idle_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        halted |-> !push) else $error("capture during idle stop");
    a_alone_16: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !cascaded && run && tick_sel && !clear_cnt |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
        else $error("own clock not counted");
endmodule : icdt_channel
`default_nettype wire

/* File: rtl/icdt_pkg.sv */
// constants, register layout and types for the input capture channel
`default_nettype none
package icdt_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int CNT_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int SRC_N = 32;
    // register addresses
    localparam logic [1:0] ADDR_CTRL1 = 2'h0;
    localparam logic [1:0] ADDR_CTRL2 = 2'h1;
    localparam logic [1:0] ADDR_FIFO = 2'h2;
    localparam logic [1:0] ADDR_COUNT = 2'h3;
    // control one fields
    localparam int C1_MODE_LSB = 0;
    localparam int C1_BNE = 3;
    localparam int C1_OVF = 4;
    localparam int C1_RATE_LSB = 5;
    localparam int C1_TSEL_LSB = 10;
    localparam int C1_SIDL = 13;
    // control two fields
    localparam int C2_SYNC_LSB = 0;
    localparam int C2_TSTAT = 6;
    localparam int C2_TRIG = 7;
    localparam int C2_CASC = 8;
    localparam logic [15:0] C1_RESET = 16'h0000;
    localparam logic [4:0] SYNC_RESET = 5'h0d;
    localparam logic [4:0] SYNC_NONE = 5'h00;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_EDGE = 3'h1;
    localparam logic [2:0] MODE_FALL = 3'h2;
    localparam logic [2:0] MODE_RISE = 3'h3;
    localparam logic [2:0] MODE_RISE4 = 3'h4;
    localparam logic [2:0] MODE_RISE16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_INTPIN = 3'h7;
    localparam logic [3:0] PRE4_LAST = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hf;
    localparam logic [2:0] TSEL_SYS = 3'h7;
    localparam logic [2:0] TSEL_RSV6 = 3'h6;
    localparam logic [2:0] TSEL_RSV5 = 3'h5;
    localparam logic [2:0] TSEL_T1 = 3'h4;
    localparam logic [2:0] TSEL_T5 = 3'h3;
    localparam logic [2:0] TSEL_T4 = 3'h2;
    localparam logic [2:0] TSEL_T2 = 3'h1;
    localparam logic [2:0] TSEL_T3 = 3'h0;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    typedef enum logic [1:0] {
        ICDT_FREE,
        ICDT_SYNC,
        ICDT_TRIG,
        ICDT_SWTRIG
    } icdt_tb_mode_e;
endpackage : icdt_pkg
`default_nettype wire

/* File: rtl/icdt_fifo_mem.sv */
// four-entry capture storage with registered read data
`default_nettype none
module icdt_fifo_mem (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [icdt_pkg::PTR_W-1:0] wr_addr_i,
    input wire logic [icdt_pkg::CNT_W-1:0] wr_data_i,
    input wire logic [icdt_pkg::PTR_W-1:0] rd_addr_i,
    output logic [icdt_pkg::CNT_W-1:0] rd_data_o
);
    logic [icdt_pkg::CNT_W-1:0] mem_reg [icdt_pkg::FIFO_DEPTH];
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= icdt_pkg::CNT_ZERO;
        end else begin
            rd_data_o <= mem_reg[rd_addr_i];
        end
    end
endmodule : icdt_fifo_mem
`default_nettype wire

/* File: rtl/icdt_edge_det.sv */
// capture input edge detection and prescaled event qualification
`default_nettype none
module icdt_edge_det (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic capture_input_i,
    input wire logic run_i,
    input wire logic [2:0] capture_mode_sel_i,
    output logic event_o,
    output logic rise_o
);
    logic in_reg;
    logic [3:0] pre_reg;
    logic [3:0] pre_next;
    logic rise;
    logic fall;
    logic pre_last;
    assign rise = capture_input_i & ~in_reg;
    assign fall = ~capture_input_i & in_reg;
    assign rise_o = rise;
    assign pre_last = (capture_mode_sel_i == icdt_pkg::MODE_RISE4) ? (pre_reg == icdt_pkg::PRE4_LAST)
                                                                    : (pre_reg == icdt_pkg::PRE16_LAST);
    // selects which edges count as captures
    always_comb begin
        event_o = 1'b0;
        pre_next = pre_reg;
        case (capture_mode_sel_i)
            icdt_pkg::MODE_EDGE: event_o = rise | fall;
            icdt_pkg::MODE_FALL: event_o = fall;
            icdt_pkg::MODE_RISE: event_o = rise;
            icdt_pkg::MODE_RISE4, icdt_pkg::MODE_RISE16: begin
                if (rise) begin
                    event_o = pre_last;
                    pre_next = pre_last ? 4'h0 : 4'(pre_reg + 4'h1);
                end
            end
            default: begin
                event_o = 1'b0;
                pre_next = 4'h0;
            end
        endcase
        if (!run_i) begin
            event_o = 1'b0;
            pre_next = 4'h0;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_reg <= 1'b0;
            pre_reg <= 4'h0;
        end else begin
            in_reg <= capture_input_i;
            pre_reg <= pre_next;
        end
    end
endmodule : icdt_edge_det
`default_nettype wire

/* File: testbench/icdt_pulse_src.sv */
// capture pin driver standing in for the external pulse source
`default_nettype none
module icdt_pulse_src (
    input wire logic clk_i,
    output logic capture_input_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial capture_input_o = 1'b0;
    // n pulses, high for hi cycles then low for lo cycles, idle low
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            @(posedge clk_i);
            capture_input_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
            capture_input_o <= 1'b0;
            repeat (lo - 1) @(posedge clk_i);
        end
    endtask : pulses
endmodule : icdt_pulse_src
`default_nettype wire

/* File: testbench/icdt_channel_test.sv */
// self-checking bench for the input capture channel
`default_nettype none
module icdt_channel_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic cap_in;
    logic [4:0] timer_tick_i = 5'h00;
    logic [31:0] sync_event_i = 32'h0000_0000;
    logic [31:0] sync_enabled_i = 32'h0000_0000;
    logic cpu_idle_i = 1'b0;
    logic cpu_sleep_i = 1'b0;
    logic p_casc = 1'b0;
    logic p_wrap = 1'b0;
    logic p_run = 1'b0;
    logic p_clr = 1'b0;
    logic cascade_o;
    logic capture_irq_o;
    logic run_w;
    logic clr_w;
    int failures = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    logic [15:0] v;
    int n;

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (capture_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;

    icdt_pulse_src src (.clk_i(clk_i), .capture_input_o(cap_in));
    icdt_channel #(.IS_ODD(1'b0)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_i(cap_in), .timer_tick_i(timer_tick_i),
        .sync_event_i(sync_event_i), .sync_enabled_i(sync_enabled_i), .cpu_idle_i(cpu_idle_i),
        .cpu_sleep_i(cpu_sleep_i), .partner_cascade_i(p_casc), .partner_wrap_i(p_wrap), .partner_run_i(p_run),
        .partner_clear_i(p_clr), .cascade_o(cascade_o), .wrap_o(), .run_o(run_w), .clear_o(clr_w),
        .capture_irq_o(capture_irq_o));

    function automatic logic [15:0] c1(logic [2:0] m, int r, logic [2:0] t, int s);
        return {2'b00, 1'(s), t, 3'b000, 2'(r), 2'b00, m};
    endfunction : c1
    function automatic logic [15:0] c2(int c, int tr, int ts, logic [4:0] sy);
        return {7'h00, 1'(c), 1'(tr), 1'(ts), 1'b0, sy};
    endfunction : c2
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // two counter reads five idle cycles apart are seven edges apart
    task automatic tdiff(input logic [15:0] e);
        logic [15:0] a;
        logic [15:0] b;
        rd(icdt_pkg::ADDR_COUNT, a);
        repeat (5) @(posedge clk_i);
        rd(icdt_pkg::ADDR_COUNT, b);
        chk(b - a, e, "counter step");
    endtask : tdiff
    task automatic flag(input int bit_n, input logic e);
        rd(icdt_pkg::ADDR_CTRL1, v);
        chk({15'h0000, v[bit_n]}, {15'h0000, e}, "status flag");
    endtask : flag
    task automatic drain(output int cnt);
        cnt = 0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rd(icdt_pkg::ADDR_CTRL1, v);
            if (v[icdt_pkg::C1_BNE] !== 1'b1) break;
            rd(icdt_pkg::ADDR_FIFO, v);
            cnt++;
        end
    endtask : drain
    task automatic pulse_sync(input int s);
        @(posedge clk_i);
        sync_event_i[s] <= 1'b1;
        @(posedge clk_i);
        sync_event_i[s] <= 1'b0;
    endtask : pulse_sync

    task automatic t_reset();
        rd(icdt_pkg::ADDR_CTRL1, v);
        chk(v, 16'h0000, "ctrl1 reset");
        rd(icdt_pkg::ADDR_CTRL2, v);
        chk(v, 16'h000d, "ctrl2 reset");
        tdiff(16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_free();
        logic [15:0] x;
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 0, 0, icdt_pkg::SYNC_NONE));
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, icdt_pkg::TSEL_SYS, 0));
        tdiff(16'h0007);
        src.pulses(2, 3, 3);
        repeat (4) @(posedge clk_i);
        flag(icdt_pkg::C1_BNE, 1'b1);
        rd(icdt_pkg::ADDR_FIFO, x);
        rd(icdt_pkg::ADDR_FIFO, v);
        chk(v - x, 16'h0006, "capture spacing");
        flag(icdt_pkg::C1_BNE, 1'b0);
        $display("test free done");
    endtask : t_free
    task automatic t_modes();
        logic [2:0] md[8] = '{0, 1, 2, 3, 4, 5, 6, 7};
        int np[8] = '{3, 1, 3, 3, 8, 16, 3, 3};
        int ex[8] = '{0, 2, 3, 3, 2, 1, 0, 0};
        for (int i = 0; i < 8; i++) begin
            wr(icdt_pkg::ADDR_CTRL1, c1(md[i], 0, icdt_pkg::TSEL_SYS, 0));
            src.pulses(np[i], 2, 2);
            drain(n);
            chk(16'(n), 16'(ex[i]), "captures per mode");
            wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_OFF, 0, icdt_pkg::TSEL_SYS, 0));
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_ovf();
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, icdt_pkg::TSEL_SYS, 0));
        src.pulses(5, 2, 2);
        repeat (4) @(posedge clk_i);
        flag(icdt_pkg::C1_OVF, 1'b1);
        drain(n);
        chk(16'(n), 16'(icdt_pkg::FIFO_DEPTH), "fifo depth");
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_OFF, 0, icdt_pkg::TSEL_SYS, 0));
        flag(icdt_pkg::C1_OVF, 1'b0);
        $display("test overflow done");
    endtask : t_ovf
    task automatic t_rate();
        for (int r = 0; r < 5; r++) begin
            wr(icdt_pkg::ADDR_CTRL1, c1(r < 4 ? icdt_pkg::MODE_RISE : icdt_pkg::MODE_EDGE, r < 4 ? r : 3, 3'h7, 0));
            irq_cnt = 0;
            src.pulses(r < 4 ? 4 : 2, 2, 2);
            drain(n);
            chk(16'(irq_cnt), r < 4 ? 16'(4 / (r + 1)) : 16'h0004, "interrupt count");
            wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_OFF, 0, icdt_pkg::TSEL_SYS, 0));
        end
        cpu_sleep_i <= 1'b1;
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_INTPIN, 0, icdt_pkg::TSEL_SYS, 0));
        irq_cnt = 0;
        src.pulses(2, 2, 2);
        repeat (4) @(posedge clk_i);
        chk(16'(irq_cnt), 16'h0002, "wake pin interrupts");
        cpu_sleep_i <= 1'b0;
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_OFF, 0, icdt_pkg::TSEL_SYS, 0));
        $display("test rate done");
    endtask : t_rate
    task automatic t_trig();
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 1, 0, icdt_pkg::SYNC_NONE));
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, icdt_pkg::TSEL_SYS, 0));
        tdiff(16'h0000);
        src.pulses(1, 2, 2);
        drain(n);
        chk(16'(n), 16'h0000, "captures before software start");
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 1, 1, icdt_pkg::SYNC_NONE));
        tdiff(16'h0007);
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 1, 0, 5'h0b));
        sync_enabled_i[11] <= 1'b1;
        tdiff(16'h0000);
        pulse_sync(11);
        repeat (2) @(posedge clk_i);
        rd(icdt_pkg::ADDR_CTRL2, v);
        chk({15'h0000, v[icdt_pkg::C2_TSTAT]}, 16'h0001, "trigger status");
        tdiff(16'h0007);
        $display("test trigger done");
    endtask : t_trig
    task automatic t_sync();
        sync_enabled_i <= 32'h0000_0000;
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 0, 0, 5'h0b));
        tdiff(16'h0000);
        sync_enabled_i[11] <= 1'b1;
        tdiff(16'h0007);
        repeat (20) @(posedge clk_i);
        pulse_sync(11);
        rd(icdt_pkg::ADDR_COUNT, v);
        chk(16'(v < 16'h0004), 16'h0001, "counter after sync event");
        $display("test sync done");
    endtask : t_sync
    task automatic t_tsel();
        logic [2:0] ts[5] = '{4, 1, 0, 2, 3};
        logic [15:0] a;
        wr(icdt_pkg::ADDR_CTRL2, c2(0, 0, 0, icdt_pkg::SYNC_NONE));
        for (int i = 0; i < 5; i++) begin
            wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, ts[i], 0));
            rd(icdt_pkg::ADDR_COUNT, a);
            repeat (5) begin
                @(posedge clk_i);
                timer_tick_i[i] <= 1'b1;
                @(posedge clk_i);
                timer_tick_i[i] <= 1'b0;
            end
            rd(icdt_pkg::ADDR_COUNT, v);
            chk(v - a, 16'h0005, "ticks counted");
        end
        $display("test time base done");
    endtask : t_tsel
    task automatic t_idle();
        logic [15:0] a;
        cpu_idle_i <= 1'b1;
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, icdt_pkg::TSEL_SYS, 1));
        tdiff(16'h0000);
        wr(icdt_pkg::ADDR_CTRL1, c1(icdt_pkg::MODE_RISE, 0, icdt_pkg::TSEL_SYS, 0));
        tdiff(16'h0007);
        cpu_idle_i <= 1'b0;
        p_run <= 1'b1;
        wr(icdt_pkg::ADDR_CTRL2, c2(1, 0, 0, icdt_pkg::SYNC_NONE));
        #1;
        chk({15'h0000, cascade_o}, 16'h0001, "cascade enable out");
        tdiff(16'h0007);
        p_casc <= 1'b1;
        rd(icdt_pkg::ADDR_COUNT, a);
        repeat (3) begin
            @(posedge clk_i);
            p_wrap <= 1'b1;
            @(posedge clk_i);
            p_wrap <= 1'b0;
        end
        rd(icdt_pkg::ADDR_COUNT, v);
        chk(v - a, 16'h0003, "partner wraps counted");
        chk({14'h0000, run_w, clr_w}, 16'h0002, "cascade run and clear");
        p_clr <= 1'b1;
        tdiff(16'h0000);
        chk({14'h0000, run_w, clr_w}, 16'h0003, "cascade run and clear");
        $display("test idle and cascade done");
    endtask : t_idle

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #(40 * 20000);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_free();
        t_modes();
        t_ovf();
        t_rate();
        t_trig();
        t_sync();
        t_tsel();
        t_idle();
        end_of_test();
    end
endmodule : icdt_channel_test
`default_nettype wire
